//--- design/nvm_core_ctrl.sv
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module nvm_core_ctrl #(
  parameter int WARM_CYCLES = nvm_pkg::READ_WARM_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Software port
  input wire logic [4:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  output logic irq,
  // Memory block
  nvm_if.core nvm
);
  typedef enum logic [11:0] {
    C_IDLE = 12'h001, C_FILL = 12'h002, C_PG_LO = 12'h004, C_PG_HI = 12'h008,
    C_CLR = 12'h010, C_KEY = 12'h020, C_START = 12'h040, C_PWAIT = 12'h080,
    C_CHECK = 12'h100, C_GATE = 12'h200, C_TREAD = 12'h400, C_TWAIT = 12'h800
  } ctrl_e;

  ctrl_e state_reg;
  logic [7:0] stage [0:nvm_pkg::PAGE_BYTES-1];
  logic [5:0] page_reg;
  logic [9:0] dptr_reg;
  logic [9:0] result_reg;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] mask_reg;
  logic irq_reg;
  logic [7:0] sw_rdata_reg;
  logic op_prog_reg;
  logic gate_reg;
  logic [4:0] idx_reg;
  logic [4:0] idx_next;
  logic [10:0] warm_reg;
  logic warm_done;
  logic cmd_wr;
  logic [2:0] ev;
  logic wr_en_reg;
  logic rd_en_reg;
  logic [8:0] addr_reg;
  logic [3:0] wdata_reg;
  logic tr_req_reg;
  logic [13:0] dp_reg;

  function automatic logic [3:0] nibble_of(input logic [7:0] b, input logic hi);
    nibble_of = hi ? b[7:4] : b[3:0];
  endfunction

  assign cmd_wr = sw_wr && sw_addr == nvm_pkg::SW_CMD && sw_wdata[4:0] != 5'h00;
  assign idx_next = idx_reg + 5'h01;
  assign warm_done = warm_reg == 11'(WARM_CYCLES);

  // Events
  always_comb begin
    ev = nvm_pkg::EV_RESET;
    ev[nvm_pkg::EV_OP_DONE] = state_reg == C_CHECK && nvm.rdata[nvm_pkg::CTL_DONE];
    ev[nvm_pkg::EV_READ] = state_reg == C_TWAIT && nvm.tr_valid;
    ev[nvm_pkg::EV_REFUSED] = cmd_wr && state_reg != C_IDLE;
    // Set wins over a write-one-to-clear in the same cycle
    status_next = status_reg;
    if (sw_wr && sw_addr == nvm_pkg::SW_STATUS) begin
      status_next = status_reg & ~sw_wdata[2:0];
    end
    status_next = status_next | ev;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_reg <= nvm_pkg::EV_RESET;
      mask_reg <= nvm_pkg::EV_RESET;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      if (sw_wr && sw_addr == nvm_pkg::SW_MASK) begin
        mask_reg <= sw_wdata[2:0];
      end
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // Software-written settings and page staging
  always_ff @(posedge clk) begin
    if (!rstn) begin
      page_reg <= 6'h00;
      dptr_reg <= 10'h000;
    end else if (sw_wr) begin
      if (sw_addr == nvm_pkg::SW_PAGE) begin
        page_reg <= sw_wdata[5:0];
      end
      if (sw_addr == nvm_pkg::SW_DPTR_LO) begin
        dptr_reg[7:0] <= sw_wdata;
      end
      if (sw_addr == nvm_pkg::SW_DPTR_HI) begin
        dptr_reg[9:8] <= sw_wdata[1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sw_wr && sw_addr[nvm_pkg::SW_BUF_BIT]) begin
      stage[sw_addr[3:0]] <= sw_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sw_rdata_reg <= 8'h00;
    end else if (!sw_rd) begin
      sw_rdata_reg <= 8'h00;
    end else if (sw_addr[nvm_pkg::SW_BUF_BIT]) begin
      sw_rdata_reg <= stage[sw_addr[3:0]];
    end else begin
      case (sw_addr)
        nvm_pkg::SW_CMD: sw_rdata_reg <= {7'h00, state_reg != C_IDLE};
        nvm_pkg::SW_PAGE: sw_rdata_reg <= {2'h0, page_reg};
        nvm_pkg::SW_STATUS: sw_rdata_reg <= {5'h00, status_reg};
        nvm_pkg::SW_MASK: sw_rdata_reg <= {5'h00, mask_reg};
        nvm_pkg::SW_DPTR_LO: sw_rdata_reg <= dptr_reg[7:0];
        nvm_pkg::SW_DPTR_HI: sw_rdata_reg <= {6'h00, dptr_reg[9:8]};
        nvm_pkg::SW_READ_LO: sw_rdata_reg <= result_reg[7:0];
        nvm_pkg::SW_READ_HI: sw_rdata_reg <= {5'h00, gate_reg, result_reg[9:8]};
        default: sw_rdata_reg <= 8'h00;
      endcase
    end
  end

  // Read path warm-up; a table read with the gate on waits until this expires
  always_ff @(posedge clk) begin
    if (!rstn || !gate_reg) begin
      warm_reg <= 11'h000;
    end else if (!warm_done) begin
      warm_reg <= warm_reg + 11'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= C_IDLE;
      op_prog_reg <= 1'b0;
      gate_reg <= 1'b0;
      idx_reg <= 5'h00;
      result_reg <= 10'h000;
      wr_en_reg <= 1'b0;
      rd_en_reg <= 1'b0;
      addr_reg <= 9'h000;
      wdata_reg <= 4'h0;
      tr_req_reg <= 1'b0;
      dp_reg <= 14'h0000;
    end else begin
      case (state_reg)
        C_IDLE: begin
          wr_en_reg <= 1'b0;
          rd_en_reg <= 1'b0;
          tr_req_reg <= 1'b0;
          if (cmd_wr) begin
            if (sw_wdata[nvm_pkg::CMD_ERASE]) begin
              op_prog_reg <= 1'b0;
              wr_en_reg <= 1'b1;
              addr_reg <= nvm_pkg::ADDR_CONTROL;
              wdata_reg <= {2'h0, gate_reg, 1'b0};
              state_reg <= C_CLR;
            end else if (sw_wdata[nvm_pkg::CMD_PROG]) begin
              // Buffer and page go in before the start bit
              op_prog_reg <= 1'b1;
              idx_reg <= 5'h00;
              wr_en_reg <= 1'b1;
              addr_reg <= nvm_pkg::BUF_BASE;
              wdata_reg <= nibble_of(stage[0], 1'b0);
              state_reg <= C_FILL;
            end else if (sw_wdata[nvm_pkg::CMD_GATE_ON] || sw_wdata[nvm_pkg::CMD_GATE_OFF]) begin
              gate_reg <= sw_wdata[nvm_pkg::CMD_GATE_ON];
              wr_en_reg <= 1'b1;
              addr_reg <= nvm_pkg::ADDR_CONTROL;
              wdata_reg <= {2'h0, sw_wdata[nvm_pkg::CMD_GATE_ON], 1'b0};
              state_reg <= C_GATE;
            end else begin
              state_reg <= C_TREAD;
            end
          end
        end
        C_FILL: begin
          if (idx_reg == 5'(nvm_pkg::BUF_NIBBLES - 1)) begin
            addr_reg <= nvm_pkg::ADDR_PAGE_LO;
            wdata_reg <= page_reg[3:0];
            state_reg <= C_PG_LO;
          end else begin
            idx_reg <= idx_next;
            addr_reg <= nvm_pkg::BUF_BASE | {4'h0, idx_next};
            wdata_reg <= nibble_of(stage[idx_next[4:1]], idx_next[0]);
          end
        end
        C_PG_LO: begin
          addr_reg <= nvm_pkg::ADDR_PAGE_HI;
          wdata_reg <= {2'h0, page_reg[5:4]};
          state_reg <= C_PG_HI;
        end
        C_PG_HI: begin
          addr_reg <= nvm_pkg::ADDR_CONTROL;
          wdata_reg <= {2'h0, gate_reg, 1'b0};
          state_reg <= C_CLR;
        end
        C_CLR: begin
          // Done flag was cleared by the previous write
          addr_reg <= nvm_pkg::ADDR_KEY;
          wdata_reg <= nvm_pkg::UNLOCK_KEY;
          state_reg <= C_KEY;
        end
        C_KEY: begin
          addr_reg <= nvm_pkg::ADDR_CONTROL;
          wdata_reg <= {!op_prog_reg, op_prog_reg, gate_reg, 1'b0};
          state_reg <= C_START;
        end
        C_START: begin
          wr_en_reg <= 1'b0;
          rd_en_reg <= 1'b1;
          state_reg <= C_PWAIT;
        end
        C_PWAIT: begin
          rd_en_reg <= 1'b0;
          state_reg <= C_CHECK;
        end
        C_CHECK: begin
          if (nvm.rdata[nvm_pkg::CTL_DONE]) begin
            state_reg <= C_IDLE;
          end else begin
            rd_en_reg <= 1'b1;
            state_reg <= C_PWAIT;
          end
        end
        C_GATE: begin
          wr_en_reg <= 1'b0;
          state_reg <= C_IDLE;
        end
        C_TREAD: begin
          if (!gate_reg || warm_done) begin
            tr_req_reg <= 1'b1;
            dp_reg <= nvm_pkg::TABLE_BASE | {4'h0, dptr_reg};
            state_reg <= C_TWAIT;
          end
        end
        C_TWAIT: begin
          tr_req_reg <= 1'b0;
          if (nvm.tr_valid) begin
            result_reg <= {nvm.table_data_top, nvm.table_data_mid, nvm.table_data_acc};
            state_reg <= C_IDLE;
          end
        end
        default: state_reg <= C_IDLE;
      endcase
    end
  end

  assign sw_rdata = sw_rdata_reg;
  assign irq = irq_reg;
  assign nvm.wr_en = wr_en_reg;
  assign nvm.rd_en = rd_en_reg;
  assign nvm.addr = addr_reg;
  assign nvm.wdata = wdata_reg;
  assign nvm.tr_req = tr_req_reg;
  assign nvm.data_pointer = dp_reg;
endmodule

//--- design/nvm_device.sv
`timescale 1ns/1ps
module nvm_device #(
  parameter int ERASE_CYCLES = nvm_pkg::ERASE_CYCLES,
  parameter int PROG_CYCLES = nvm_pkg::PROG_CYCLES,
  parameter int WARM_CYCLES = nvm_pkg::READ_WARM_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Core side
  nvm_if.device nvm,
  // Status
  output logic nvm_busy,
  output logic nvm_done_flag
);
  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_ERASE = 3'b010,
    D_PROG = 3'b100
  } dev_e;

  localparam int CW = $clog2(ERASE_CYCLES) + 1;

  dev_e state_reg;
  logic [7:0] mem [0:nvm_pkg::MEM_BYTES-1];
  logic [3:0] buf_nib [0:nvm_pkg::BUF_NIBBLES-1];
  logic [CW-1:0] cnt_reg;
  logic [nvm_pkg::PAGE_W-1:0] page_act_reg;
  logic [3:0] page_lo_reg;
  logic [1:0] page_hi_reg;
  logic done_reg;
  logic gate_reg;
  logic unlock_reg;
  logic busy_reg;
  logic [10:0] warm_reg;
  logic warm_done;
  logic [3:0] rdata_reg;
  logic tr_valid_reg;
  logic [3:0] mid_reg;
  logic [3:0] acc_reg;
  logic wr_ctl;
  logic start_prog;
  logic start_erase;
  logic op_end;
  logic [7:0] rd_byte;
  logic tr_hit;

  function automatic logic in_buf(input logic [8:0] a);
    in_buf = a >= nvm_pkg::BUF_BASE && a <= nvm_pkg::BUF_LAST;
  endfunction

  assign wr_ctl = nvm.wr_en && nvm.addr == nvm_pkg::ADDR_CONTROL;
  // Requests count only while unlocked and idle; erase wins a tie
  assign start_erase = wr_ctl && nvm.wdata[nvm_pkg::CTL_ERASE] && unlock_reg && state_reg == D_IDLE;
  assign start_prog = wr_ctl && nvm.wdata[nvm_pkg::CTL_PROG] && !nvm.wdata[nvm_pkg::CTL_ERASE]
                      && unlock_reg && state_reg == D_IDLE;
  assign op_end = (state_reg == D_ERASE && cnt_reg == CW'(ERASE_CYCLES - 1))
                  || (state_reg == D_PROG && cnt_reg == CW'(PROG_CYCLES - 1));
  assign warm_done = warm_reg == 11'(WARM_CYCLES);

  // Operation sequencer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= D_IDLE;
      cnt_reg <= '0;
      page_act_reg <= '0;
    end else begin
      case (state_reg)
        D_IDLE: begin
          cnt_reg <= '0;
          if (start_erase) begin
            state_reg <= D_ERASE;
          end else if (start_prog) begin
            page_act_reg <= {page_hi_reg, page_lo_reg};
            state_reg <= D_PROG;
          end
        end
        D_ERASE, D_PROG: begin
          if (op_end) begin
            state_reg <= D_IDLE;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + CW'(1);
          end
        end
        default: state_reg <= D_IDLE;
      endcase
    end
  end

  // Array update: one byte per cycle so the array stays a plain memory
  always_ff @(posedge clk) begin
    if (state_reg == D_ERASE && cnt_reg < CW'(nvm_pkg::MEM_BYTES)) begin
      mem[cnt_reg[9:0]] <= nvm_pkg::ERASED_BYTE;
    end else if (state_reg == D_PROG && cnt_reg < CW'(nvm_pkg::PAGE_BYTES)) begin
      mem[{page_act_reg, cnt_reg[3:0]}] <= nvm_pkg::ERASED_BYTE;
    end else if (state_reg == D_PROG && cnt_reg < CW'(2 * nvm_pkg::PAGE_BYTES)) begin
      mem[{page_act_reg, cnt_reg[3:0]}] <= {buf_nib[{cnt_reg[3:0], 1'b1}], buf_nib[{cnt_reg[3:0], 1'b0}]};
    end
  end

  // Page buffer window, low nibble at the even address
  always_ff @(posedge clk) begin
    if (nvm.wr_en && in_buf(nvm.addr)) begin
      buf_nib[nvm.addr[4:0]] <= nvm.wdata;
    end
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      done_reg <= nvm_pkg::CTL_RESET[nvm_pkg::CTL_DONE];
      gate_reg <= nvm_pkg::CTL_RESET[nvm_pkg::CTL_GATE];
      page_lo_reg <= 4'h0;
      page_hi_reg <= 2'h0;
    end else begin
      if (op_end) begin
        done_reg <= 1'b1;
      end else if (wr_ctl && !nvm.wdata[nvm_pkg::CTL_DONE]) begin
        done_reg <= 1'b0;
      end
      if (wr_ctl) begin
        gate_reg <= nvm.wdata[nvm_pkg::CTL_GATE];
      end
      if (nvm.wr_en && nvm.addr == nvm_pkg::ADDR_PAGE_LO) begin
        page_lo_reg <= nvm.wdata;
      end
      if (nvm.wr_en && nvm.addr == nvm_pkg::ADDR_PAGE_HI) begin
        page_hi_reg <= nvm.wdata[1:0];
      end
    end
  end

  // Protection: the key opens one window, closed again by completion
  always_ff @(posedge clk) begin
    if (!rstn) begin
      unlock_reg <= 1'b0;
    end else if (op_end) begin
      unlock_reg <= 1'b0;
    end else if (nvm.wr_en && nvm.addr == nvm_pkg::ADDR_KEY) begin
      unlock_reg <= nvm.wdata == nvm_pkg::UNLOCK_KEY;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || !gate_reg) begin
      warm_reg <= 11'h000;
    end else if (!warm_done) begin
      warm_reg <= warm_reg + 11'h001;
    end
  end

  // Register reads answer in the following cycle
  always_ff @(posedge clk) begin
    if (!rstn || !nvm.rd_en) begin
      rdata_reg <= 4'h0;
    end else if (in_buf(nvm.addr)) begin
      rdata_reg <= buf_nib[nvm.addr[4:0]];
    end else begin
      case (nvm.addr)
        nvm_pkg::ADDR_CONTROL: rdata_reg <= {state_reg == D_ERASE, state_reg == D_PROG, gate_reg, done_reg};
        nvm_pkg::ADDR_KEY: rdata_reg <= {3'h0, unlock_reg};
        nvm_pkg::ADDR_PAGE_LO: rdata_reg <= page_lo_reg;
        nvm_pkg::ADDR_PAGE_HI: rdata_reg <= {2'h0, page_hi_reg};
        default: rdata_reg <= 4'h0;
      endcase
    end
  end

  // Table read; a gated or cold array returns zero mid and acc nibbles to save power
  assign rd_byte = mem[nvm.data_pointer[9:0]];
  // Out-of-range requests get no answer and show no data either
  assign tr_hit = nvm.tr_req && nvm.data_pointer >= nvm_pkg::TABLE_BASE
                  && nvm.data_pointer <= nvm_pkg::TABLE_LAST;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tr_valid_reg <= 1'b0;
      mid_reg <= 4'h0;
      acc_reg <= 4'h0;
    end else begin
      tr_valid_reg <= tr_hit;
      if (tr_hit && gate_reg && warm_done) begin
        mid_reg <= rd_byte[7:4];
        acc_reg <= rd_byte[3:0];
      end else begin
        mid_reg <= 4'h0;
        acc_reg <= 4'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= state_reg != D_IDLE && !op_end;
    end
  end

  assign nvm.rdata = rdata_reg;
  assign nvm.tr_valid = tr_valid_reg;
  assign nvm.table_data_top = nvm_pkg::TOP_READ;
  assign nvm.table_data_mid = mid_reg;
  assign nvm.table_data_acc = acc_reg;
  assign nvm_busy = busy_reg;
  assign nvm_done_flag = done_reg;
endmodule

//--- design/nvm_if.sv
`timescale 1ns/1ps
interface nvm_if;
  logic wr_en;
  logic rd_en;
  logic [8:0] addr;
  logic [3:0] wdata;
  logic [3:0] rdata;
  logic tr_req;
  logic [13:0] data_pointer;
  logic tr_valid;
  logic [1:0] table_data_top;
  logic [3:0] table_data_mid;
  logic [3:0] table_data_acc;

  modport device (
    input wr_en, rd_en, addr, wdata, tr_req, data_pointer,
    output rdata, tr_valid, table_data_top, table_data_mid, table_data_acc
  );
  modport core (
    output wr_en, rd_en, addr, wdata, tr_req, data_pointer,
    input rdata, tr_valid, table_data_top, table_data_mid, table_data_acc
  );
endinterface

//--- design/nvm_pkg.sv
package nvm_pkg;
  // Clock and timing
  localparam int CLK_NS = 8;
  localparam int ERASE_NS = 9_000_000;
  // A nominal time: rounded down to whole cycles
  localparam int ERASE_CYCLES = ERASE_NS / CLK_NS;
  localparam int PROG_CYCLES = 2048;
  localparam int READ_WARM_NS = 10_000;
  // A least time: rounded up to whole cycles
  localparam int READ_WARM_CYCLES = (READ_WARM_NS + CLK_NS - 1) / CLK_NS;

  // Memory geometry
  localparam int PAGE_W = 6;
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES = 1024;
  localparam int BUF_NIBBLES = 32;

  // Core-side register addresses
  localparam logic [8:0] ADDR_CONTROL = 9'h1F0;
  localparam logic [8:0] ADDR_KEY = 9'h1F1;
  localparam logic [8:0] ADDR_PAGE_LO = 9'h1F2;
  localparam logic [8:0] ADDR_PAGE_HI = 9'h1F3;
  localparam logic [8:0] BUF_BASE = 9'h1A0;
  localparam logic [8:0] BUF_LAST = 9'h1BF;

  // nvm_control fields
  localparam int CTL_DONE = 0;
  localparam int CTL_GATE = 1;
  localparam int CTL_PROG = 2;
  localparam int CTL_ERASE = 3;
  localparam logic [3:0] CTL_RESET = 4'h0;

  localparam logic [3:0] UNLOCK_KEY = 4'hA;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [1:0] TOP_READ = 2'h3;
  localparam logic [13:0] TABLE_BASE = 14'h2000;
  localparam logic [13:0] TABLE_LAST = 14'h23FF;

  // Controller software map
  localparam logic [4:0] SW_CMD = 5'h00;
  localparam logic [4:0] SW_PAGE = 5'h01;
  localparam logic [4:0] SW_STATUS = 5'h02;
  localparam logic [4:0] SW_MASK = 5'h03;
  localparam logic [4:0] SW_DPTR_LO = 5'h04;
  localparam logic [4:0] SW_DPTR_HI = 5'h05;
  localparam logic [4:0] SW_READ_LO = 5'h06;
  localparam logic [4:0] SW_READ_HI = 5'h07;
  localparam int SW_BUF_BIT = 4;

  localparam int CMD_ERASE = 0;
  localparam int CMD_PROG = 1;
  localparam int CMD_GATE_ON = 2;
  localparam int CMD_GATE_OFF = 3;
  localparam int CMD_TREAD = 4;

  localparam int EV_OP_DONE = 0;
  localparam int EV_READ = 1;
  localparam int EV_REFUSED = 2;
  localparam logic [2:0] EV_RESET = 3'h0;
endpackage

//--- verif/nvm_ctrl_sva.sv
`timescale 1ns/1ps
module nvm_ctrl_sva #(
  parameter int WARM_CYCLES = nvm_pkg::READ_WARM_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Core side of the memory interface
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [8:0] addr,
  input wire logic [3:0] wdata,
  input wire logic [3:0] rdata,
  input wire logic tr_req,
  input wire logic [13:0] data_pointer,
  input wire logic tr_valid,
  input wire logic [1:0] table_data_top,
  input wire logic [3:0] table_data_mid,
  input wire logic [3:0] table_data_acc,
  // Device status
  input wire logic nvm_busy,
  input wire logic nvm_done_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  logic unlk_reg;
  logic clr_req_reg;
  logic in_range_reg;
  logic gate_reg;
  int warm_cnt_reg;
  logic ctl_wr;
  logic start_wr;

  assign ctl_wr = wr_en && addr == nvm_pkg::ADDR_CONTROL;
  assign start_wr = ctl_wr && (wdata[nvm_pkg::CTL_PROG] || wdata[nvm_pkg::CTL_ERASE]);

  // The window is treated as spent once an operation is seen running
  always_ff @(posedge clk) begin
    if (!rstn) begin
      unlk_reg <= 1'b0;
    end else if (wr_en && addr == nvm_pkg::ADDR_KEY) begin
      unlk_reg <= wdata == nvm_pkg::UNLOCK_KEY;
    end else if (nvm_busy) begin
      unlk_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      clr_req_reg <= 1'b0;
      in_range_reg <= 1'b0;
    end else begin
      clr_req_reg <= ctl_wr && !wdata[nvm_pkg::CTL_DONE];
      in_range_reg <= tr_req && data_pointer >= nvm_pkg::TABLE_BASE && data_pointer <= nvm_pkg::TABLE_LAST;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      gate_reg <= 1'b0;
    end else if (ctl_wr) begin
      gate_reg <= wdata[nvm_pkg::CTL_GATE];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || !gate_reg) begin
      warm_cnt_reg <= 0;
    end else if (warm_cnt_reg < WARM_CYCLES) begin
      warm_cnt_reg <= warm_cnt_reg + 1;
    end
  end

  top_const_a: assert property (table_data_top == nvm_pkg::TOP_READ)
    else $error("top table bits not constant three");
  tr_follow_a: assert property (tr_req && data_pointer >= nvm_pkg::TABLE_BASE
    && data_pointer <= nvm_pkg::TABLE_LAST |=> tr_valid) else $error("table read in range got no answer");
  tr_range_a: assert property (tr_valid |-> in_range_reg)
    else $error("table answer without in-range request");
  read_idle_a: assert property (!rd_en |=> rdata == 4'h0)
    else $error("register read data not idle");
  table_idle_a: assert property (!tr_valid |-> table_data_mid == 4'h0 && table_data_acc == 4'h0)
    else $error("table data shown without answer");
  done_rise_a: assert property ($rose(nvm_done_flag) |-> $past(nvm_busy))
    else $error("done flag rose without an operation");
  done_clear_a: assert property ($fell(nvm_done_flag) |-> clr_req_reg)
    else $error("done flag fell without software clear");
  start_accept_a: assert property (start_wr && unlk_reg && !nvm_busy |-> ##[1:3] nvm_busy)
    else $error("unlocked start request not taken");
  start_refuse_a: assert property (start_wr && !unlk_reg && !nvm_busy |=> !nvm_busy [*3])
    else $error("locked start request was taken");
  cold_read_a: assert property (tr_valid && warm_cnt_reg < WARM_CYCLES - 2
    |-> table_data_mid == 4'h0 && table_data_acc == 4'h0) else $error("cold or gated read returned data");

  cover property ($rose(nvm_busy));
  cover property ($fell(nvm_done_flag));
  cover property (tr_valid && table_data_acc != 4'h0);
  cover property (tr_valid && warm_cnt_reg == 0);
endmodule

//--- verif/test_mtp_erase_program_read_ctrl.sv
`timescale 1ns/1ps
module test_mtp_erase_program_read_ctrl;
  localparam int WARM = 20;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] sw_addr = 5'h00;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] sw_rdata;
  logic irq;
  logic nvm_busy;
  logic nvm_done_flag;
  logic [7:0] rd;
  int errors = 0;
  int compares = 0;

  always #4 clk = ~clk;

  nvm_if i_nvm_if ();

  nvm_core_ctrl #(.WARM_CYCLES(WARM)) i_nvm_core_ctrl (.clk(clk), .rstn(rstn), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq), .nvm(i_nvm_if.core));

  nvm_device #(.ERASE_CYCLES(1100), .PROG_CYCLES(40), .WARM_CYCLES(WARM)) i_nvm_device (.clk(clk),
    .rstn(rstn), .nvm(i_nvm_if.device), .nvm_busy(nvm_busy), .nvm_done_flag(nvm_done_flag));

  nvm_ctrl_sva #(.WARM_CYCLES(WARM)) i_nvm_ctrl_sva (.clk(clk), .rstn(rstn), .wr_en(i_nvm_if.wr_en),
    .rd_en(i_nvm_if.rd_en), .addr(i_nvm_if.addr), .wdata(i_nvm_if.wdata), .rdata(i_nvm_if.rdata),
    .tr_req(i_nvm_if.tr_req), .data_pointer(i_nvm_if.data_pointer), .tr_valid(i_nvm_if.tr_valid),
    .table_data_top(i_nvm_if.table_data_top), .table_data_mid(i_nvm_if.table_data_mid),
    .table_data_acc(i_nvm_if.table_data_acc), .nvm_busy(nvm_busy), .nvm_done_flag(nvm_done_flag));

  function automatic logic [7:0] pat(input logic [3:0] k);
    return {k ^ 4'h5, ~k};
  endfunction

  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One strobe cycle then one idle cycle, so no strobe is driven twice in a time step
  task automatic sw_write(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask

  task automatic sw_read(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask

  task automatic read_check(input logic [4:0] a, input logic [7:0] exp, input string what);
    sw_read(a, rd);
    check(rd, exp, what);
  endtask

  task automatic wait_status(input int bit_no);
    for (int i = 0; i < 2000; i++) begin
      sw_read(nvm_pkg::SW_STATUS, rd);
      if (rd[bit_no] === 1'b1) begin
        return;
      end
    end
    errors++;
    $display("CHECK FAILED at %0t: status bit %0d never set", $time, bit_no);
  endtask

  task automatic table_read(input logic [9:0] off, input logic [7:0] exp, input logic gate_on);
    sw_write(nvm_pkg::SW_DPTR_LO, off[7:0]);
    sw_write(nvm_pkg::SW_DPTR_HI, {6'h00, off[9:8]});
    sw_write(nvm_pkg::SW_CMD, 8'h10);
    wait_status(nvm_pkg::EV_READ);
    sw_write(nvm_pkg::SW_STATUS, 8'h02);
    read_check(nvm_pkg::SW_READ_LO, exp, "table byte");
    sw_read(nvm_pkg::SW_READ_HI, rd);
    check({5'h00, rd[2:0]}, {5'h00, gate_on, nvm_pkg::TOP_READ}, "gate and top bits");
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    read_check(nvm_pkg::SW_STATUS, 8'h00, "status after reset");
    read_check(nvm_pkg::SW_MASK, 8'h00, "mask after reset");
    read_check(nvm_pkg::SW_CMD, 8'h00, "busy after reset");
    check({7'h00, irq}, 8'h00, "irq after reset");
    $display("reset test done");

    sw_write(nvm_pkg::SW_MASK, 8'h01);
    sw_write(nvm_pkg::SW_CMD, 8'h01);
    wait_status(nvm_pkg::EV_OP_DONE);
    check({7'h00, irq}, 8'h01, "irq on finished erase");
    sw_write(nvm_pkg::SW_STATUS, 8'h01);
    repeat (3) @(posedge clk);
    #1;
    check({7'h00, irq}, 8'h00, "irq after clear");
    $display("erase test done");

    sw_write(nvm_pkg::SW_CMD, 8'h04);
    repeat (WARM + 10) @(posedge clk);
    table_read(10'h000, nvm_pkg::ERASED_BYTE, 1'b1);
    table_read(10'h3FF, nvm_pkg::ERASED_BYTE, 1'b1);
    $display("erased read test done");

    for (int k = 0; k < 16; k++) begin
      sw_write(5'h10 + 5'(k), pat(4'(k)));
    end
    sw_write(nvm_pkg::SW_PAGE, 8'h22);
    sw_write(nvm_pkg::SW_CMD, 8'h02);
    // A second order while the first runs must be turned away
    sw_write(nvm_pkg::SW_CMD, 8'h01);
    wait_status(nvm_pkg::EV_OP_DONE);
    read_check(nvm_pkg::SW_STATUS, 8'h05, "refused and done");
    sw_write(nvm_pkg::SW_STATUS, 8'h07);
    for (int k = 0; k < 16; k++) begin
      table_read(10'h220 + 10'(k), pat(4'(k)), 1'b1);
    end
    table_read(10'h21F, nvm_pkg::ERASED_BYTE, 1'b1);
    table_read(10'h230, nvm_pkg::ERASED_BYTE, 1'b1);
    $display("program test done");

    sw_write(nvm_pkg::SW_CMD, 8'h08);
    sw_read(nvm_pkg::SW_READ_HI, rd);
    check({7'h00, rd[2]}, 8'h00, "gate off");
    // A gated array must answer with empty data
    table_read(10'h220, 8'h00, 1'b0);
    $display("gate test done");
    wrap_up();
  end
endmodule
